// file: core/anps_params.svh
// Offsets, field positions and reset values of the partner status registers
`ifndef ANPS_PARAMS_SVH
`define ANPS_PARAMS_SVH
`define ANPS_IDX_PARTNER   6'h05
`define ANPS_IDX_EXPANSION 6'h06
`define ANPS_LANE_ZERO     2'h0
`define ANPS_B_NEXT_WANTED 15
`define ANPS_B_ACK         14
`define ANPS_B_REM_FAULT   13
`define ANPS_B_MSG_PAGE    13
`define ANPS_B_RSV         12
`define ANPS_B_COMPLY      12
`define ANPS_B_TOGGLE      11
`define ANPS_B_ASM         11
`define ANPS_B_PAUSE       10
`define ANPS_F_CODE_HI     10
`define ANPS_F_ABIL_HI     9
`define ANPS_F_ABIL_LO     5
`define ANPS_F_SEL_HI      4
`define ANPS_E_PAR_FAULT   4
`define ANPS_E_LPNP        3
`define ANPS_E_LOCAL_NEXT  2
`define ANPS_E_PAGERX      1
`define ANPS_E_LPAN        0
`define ANPS_E_RSV_HI      31
`define ANPS_E_RSV_LO      5
`define ANPS_WORD_RST      16'h0000
`define ANPS_BASE_MASK     16'hefff
`define ANPS_LOCAL_NEXT    1'b1
`define ANPS_DATA_RST      32'h0000_0000
`define ANPS_UPPER_ZERO    16'h0000
`endif

// file: core/anps_partner_status_regs.sv
// Link partner ability and auto-negotiation expansion status registers
`timescale 1ns/1ps
`default_nettype none
`include "anps_params.svh"
module anps_partner_status_regs (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic        pageRxStrobe,
	input  wire logic [15:0] pageRxWord,
	input  wire logic        pageRxIsNext,
	input  wire logic        autonegDone,
	input  wire logic        autonegRestart,
	input  wire logic        parallelFaultStrobe,
	input  wire logic        partnerAutonegSeen
);
	logic [15:0]          baseWord_q;
	logic [15:0]          nextWord_q;
	anps_pkg::anps_view_t view_q;
	anps_pkg::anps_bus_t  bus_q;
	logic                 parFault_q;
	logic                 pageRx_q;
	logic                 lpAn_q;
	logic [31:0]          readData_q;
	logic                 wait_q;
	logic                 ansPartner_q;
	logic                 ansExp_q;
	logic                 ansBase_q;
	logic                 ansRead_q;
	logic                 selPartner;
	logic                 selExp;
	logic                 request;
	logic                 accept;
	logic                 readExpAccept;
	logic [15:0]          partnerView;
	logic [15:0]          expView;
	logic [31:0]          readValue;

	assign avs_readdata    = readData_q;
	assign avs_waitrequest = wait_q;

	// Address decode: byte address is four times the register index
	assign selPartner = (avs_address[7:2] == `ANPS_IDX_PARTNER) &&
		(avs_address[1:0] == `ANPS_LANE_ZERO);
	assign selExp = (avs_address[7:2] == `ANPS_IDX_EXPANSION) &&
		(avs_address[1:0] == `ANPS_LANE_ZERO);
	assign request = avs_read || avs_write;
	assign accept = request && (bus_q == anps_pkg::ANPS_BUS_ANSWER);
	assign readExpAccept = accept && avs_read && selExp && avs_byteenable[0];

	// Base page capture from the arbitration logic
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			baseWord_q <= `ANPS_WORD_RST;
		end else if (pageRxStrobe && !pageRxIsNext) begin
			baseWord_q <= pageRxWord & `ANPS_BASE_MASK;
		end
	end

	// Next page capture, code field and flags taken as received
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			nextWord_q <= `ANPS_WORD_RST;
		end else if (pageRxStrobe && pageRxIsNext) begin
			nextWord_q <= pageRxWord;
		end
	end

	// Layout select for index 0x05
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			view_q <= anps_pkg::ANPS_VIEW_BASE;
		end else begin
			unique case (view_q)
				anps_pkg::ANPS_VIEW_BASE: begin
					if (autonegDone && !autonegRestart && `ANPS_LOCAL_NEXT &&
						baseWord_q[`ANPS_B_NEXT_WANTED]) begin
						view_q <= anps_pkg::ANPS_VIEW_NEXT;
					end
				end
				anps_pkg::ANPS_VIEW_NEXT: begin
					if (autonegRestart) begin
						view_q <= anps_pkg::ANPS_VIEW_BASE;
					end
				end
			endcase
		end
	end

	// Parallel detection fault, held until renegotiation; a new fault wins
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			parFault_q <= 1'b0;
		end else if (parallelFaultStrobe) begin
			parFault_q <= 1'b1;
		end else if (autonegRestart) begin
			parFault_q <= 1'b0;
		end
	end

	// Page received flag, cleared by a read of the expansion register low byte; a new page in the same cycle wins
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pageRx_q <= 1'b0;
		end else if (pageRxStrobe) begin
			pageRx_q <= 1'b1;
		end else if (readExpAccept) begin
			pageRx_q <= 1'b0;
		end
	end

	// Partner negotiation ability
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lpAn_q <= 1'b0;
		end else begin
			lpAn_q <= partnerAutonegSeen;
		end
	end

	// Read views; every page bit is reported as the partner sent it, except reserved base bit 12 and any byte lane with its avs_byteenable bit low, which read zero
	always_comb begin
		partnerView = baseWord_q;
		if (view_q == anps_pkg::ANPS_VIEW_NEXT) begin
			partnerView = nextWord_q;
		end
		expView = `ANPS_WORD_RST;
		expView[`ANPS_E_PAR_FAULT] = parFault_q;
		expView[`ANPS_E_LPNP] = baseWord_q[`ANPS_B_NEXT_WANTED];
		expView[`ANPS_E_LOCAL_NEXT] = `ANPS_LOCAL_NEXT;
		expView[`ANPS_E_PAGERX] = pageRx_q;
		expView[`ANPS_E_LPAN] = lpAn_q;
		readValue = `ANPS_DATA_RST;
		if (selPartner) begin
			readValue = {`ANPS_UPPER_ZERO, partnerView};
		end else if (selExp) begin
			readValue = {`ANPS_UPPER_ZERO, expView};
		end
		readValue[15:8] = avs_byteenable[1] ? readValue[15:8] : 8'h00;
		readValue[7:0] = avs_byteenable[0] ? readValue[7:0] : 8'h00;
	end

	// Bus sequencing: one wait cycle, then the answer
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_q <= anps_pkg::ANPS_BUS_IDLE;
			wait_q <= 1'b1;
		end else begin
			unique case (bus_q)
				anps_pkg::ANPS_BUS_IDLE: begin
					if (request) begin
						bus_q <= anps_pkg::ANPS_BUS_ANSWER;
						wait_q <= 1'b0;
					end
				end
				anps_pkg::ANPS_BUS_ANSWER: begin
					bus_q <= anps_pkg::ANPS_BUS_IDLE;
					wait_q <= 1'b1;
				end
			endcase
		end
	end

	// Read data; all registers are read only, so writes are dropped
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			readData_q <= `ANPS_DATA_RST;
		end else if (bus_q == anps_pkg::ANPS_BUS_IDLE && avs_read) begin
			readData_q <= readValue;
		end else if (bus_q == anps_pkg::ANPS_BUS_IDLE && avs_write) begin
			readData_q <= `ANPS_DATA_RST;
		end
	end

	// Answer bookkeeping for checking
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ansPartner_q <= 1'b0;
			ansExp_q <= 1'b0;
			ansBase_q <= 1'b0;
			ansRead_q <= 1'b0;
		end else if (bus_q == anps_pkg::ANPS_BUS_IDLE && request) begin
			ansPartner_q <= selPartner && (avs_byteenable == 4'hf);
			ansExp_q <= selExp && (avs_byteenable == 4'hf);
			ansBase_q <= (view_q == anps_pkg::ANPS_VIEW_BASE);
			ansRead_q <= avs_read;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	property p_base_capture;
		pageRxStrobe && !pageRxIsNext |=>
			baseWord_q == ($past(pageRxWord) & `ANPS_BASE_MASK);
	endproperty
	a_base_capture: assert property (p_base_capture)
		else $error("base page not captured");

	property p_view_next;
		view_q == anps_pkg::ANPS_VIEW_BASE && autonegDone && !autonegRestart &&
			baseWord_q[`ANPS_B_NEXT_WANTED] |=> view_q == anps_pkg::ANPS_VIEW_NEXT;
	endproperty
	a_view_next: assert property (p_view_next)
		else $error("next page layout not selected");

	property p_wanted_read;
		!wait_q && ansRead_q && ansPartner_q && ansBase_q |->
			avs_readdata[`ANPS_B_NEXT_WANTED] == $past(baseWord_q[`ANPS_B_NEXT_WANTED]);
	endproperty
	a_wanted_read: assert property (p_wanted_read)
		else $error("next page wanted bit wrong");

	property p_rsv_zero;
		!wait_q && ansRead_q && ansPartner_q && ansBase_q |->
			!avs_readdata[`ANPS_B_RSV];
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved base bit read as one");

	property p_next_fields;
		pageRxStrobe && pageRxIsNext |=>
			nextWord_q[`ANPS_F_CODE_HI:0] == $past(pageRxWord[`ANPS_F_CODE_HI:0]) &&
			nextWord_q[`ANPS_B_TOGGLE] == $past(pageRxWord[`ANPS_B_TOGGLE]);
	endproperty
	a_next_fields: assert property (p_next_fields)
		else $error("next page code or toggle not captured");

	property p_exp_upper;
		!wait_q && ansRead_q && ansExp_q |->
			avs_readdata[`ANPS_E_RSV_HI:`ANPS_E_RSV_LO] == 27'h0000000 &&
			avs_readdata[`ANPS_E_LOCAL_NEXT];
	endproperty
	a_exp_upper: assert property (p_exp_upper)
		else $error("expansion reserved or fixed bit wrong");

	property p_pdf_set;
		parallelFaultStrobe ##1 !autonegRestart |-> parFault_q [*2];
	endproperty
	a_pdf_set: assert property (p_pdf_set)
		else $error("parallel fault not held");

	property p_page_set;
		pageRxStrobe |=> pageRx_q;
	endproperty
	a_page_set: assert property (p_page_set)
		else $error("page received flag not set");

	property p_page_clear;
		readExpAccept && !pageRxStrobe |=> !pageRx_q;
	endproperty
	a_page_clear: assert property (p_page_clear)
		else $error("page received flag not cleared by read");

	property p_lpan;
		!wait_q && ansRead_q && ansExp_q |->
			avs_readdata[`ANPS_E_LPAN] == $past(lpAn_q);
	endproperty
	a_lpan: assert property (p_lpan)
		else $error("partner negotiation ability wrong");

	property p_wait_answer;
		request && wait_q |=> !wait_q ##1 wait_q;
	endproperty
	a_wait_answer: assert property (p_wait_answer)
		else $error("bus answer not given after one wait cycle");

	property p_ack_read;
		!wait_q && ansRead_q && ansPartner_q |-> avs_readdata[`ANPS_B_ACK] ==
			(ansBase_q ? $past(baseWord_q[`ANPS_B_ACK]) : $past(nextWord_q[`ANPS_B_ACK]));
	endproperty
	a_ack_read: assert property (p_ack_read)
		else $error("partner acknowledge bit wrong");

	property p_fault_read;
		!wait_q && ansRead_q && ansPartner_q && ansBase_q |->
			avs_readdata[`ANPS_B_REM_FAULT] == $past(baseWord_q[`ANPS_B_REM_FAULT]);
	endproperty
	a_fault_read: assert property (p_fault_read)
		else $error("partner remote fault bit wrong");

	property p_pause_read;
		!wait_q && ansRead_q && ansPartner_q && ansBase_q |->
			avs_readdata[`ANPS_B_ASM:`ANPS_B_PAUSE] == $past(baseWord_q[`ANPS_B_ASM:`ANPS_B_PAUSE]);
	endproperty
	a_pause_read: assert property (p_pause_read)
		else $error("partner pause bits wrong");

	property p_abil_read;
		!wait_q && ansRead_q && ansPartner_q && ansBase_q |-> avs_readdata[`ANPS_F_ABIL_HI:
			`ANPS_F_ABIL_LO] == $past(baseWord_q[`ANPS_F_ABIL_HI:`ANPS_F_ABIL_LO]);
	endproperty
	a_abil_read: assert property (p_abil_read)
		else $error("partner technology bits wrong");

	property p_sel_read;
		!wait_q && ansRead_q && ansPartner_q && ansBase_q |->
			avs_readdata[`ANPS_F_SEL_HI:0] == $past(baseWord_q[`ANPS_F_SEL_HI:0]);
	endproperty
	a_sel_read: assert property (p_sel_read)
		else $error("partner selector field wrong");

	property p_msg_page;
		pageRxStrobe && pageRxIsNext |=>
			nextWord_q[`ANPS_B_MSG_PAGE] == $past(pageRxWord[`ANPS_B_MSG_PAGE]);
	endproperty
	a_msg_page: assert property (p_msg_page)
		else $error("message page bit not captured");

	property p_comply;
		pageRxStrobe && pageRxIsNext |=>
			nextWord_q[`ANPS_B_COMPLY] == $past(pageRxWord[`ANPS_B_COMPLY]);
	endproperty
	a_comply: assert property (p_comply)
		else $error("comply bit not captured");

	property p_toggle_read;
		!wait_q && ansRead_q && ansPartner_q && !ansBase_q |->
			avs_readdata[`ANPS_B_TOGGLE] == $past(nextWord_q[`ANPS_B_TOGGLE]);
	endproperty
	a_toggle_read: assert property (p_toggle_read)
		else $error("toggle bit wrong");

	property p_lpnp_read;
		!wait_q && ansRead_q && ansExp_q |->
			avs_readdata[`ANPS_E_LPNP] == $past(baseWord_q[`ANPS_B_NEXT_WANTED]);
	endproperty
	a_lpnp_read: assert property (p_lpnp_read)
		else $error("partner next page ability wrong");

	property p_view_back;
		view_q == anps_pkg::ANPS_VIEW_NEXT && autonegRestart |=>
			view_q == anps_pkg::ANPS_VIEW_BASE;
	endproperty
	a_view_back: assert property (p_view_back)
		else $error("base layout not restored on renegotiation");

	property p_cover_next;
		view_q == anps_pkg::ANPS_VIEW_NEXT && ansRead_q && !wait_q;
	endproperty
	c_cover_next: cover property (p_cover_next);

	property p_cover_clear;
		readExpAccept && pageRx_q;
	endproperty
	c_cover_clear: cover property (p_cover_clear);

	property p_cover_race;
		readExpAccept && pageRxStrobe;
	endproperty
	c_cover_race: cover property (p_cover_race);
endmodule : anps_partner_status_regs
`default_nettype wire

// file: core/anps_pkg.sv
// Types shared by the partner status register bank
package anps_pkg;
	typedef enum logic {ANPS_VIEW_BASE, ANPS_VIEW_NEXT} anps_view_t;
	typedef enum logic {ANPS_BUS_IDLE, ANPS_BUS_ANSWER} anps_bus_t;
endpackage : anps_pkg

// file: verification/anps_link_partner_model.sv
// Link partner model feeding received pages into the status bank
`timescale 1ns/1ps
`default_nettype none
module anps_link_partner_model (
	input  wire logic        sys_clk,
	output var  logic        pageRxStrobe,
	output var  logic [15:0] pageRxWord,
	output var  logic        pageRxIsNext,
	output var  logic        autonegDone,
	output var  logic        autonegRestart,
	output var  logic        parallelFaultStrobe,
	output var  logic        partnerAutonegSeen
);
	initial begin
		pageRxStrobe = 1'b0;
		pageRxWord = 16'h0000;
		pageRxIsNext = 1'b0;
		autonegDone = 1'b0;
		autonegRestart = 1'b0;
		parallelFaultStrobe = 1'b0;
		partnerAutonegSeen = 1'b0;
	end
	// Word is valid only with the strobe, then shows its inverse
	task automatic sendPage(input logic [15:0] w, input logic nxt);
		@(posedge sys_clk);
		pageRxStrobe <= 1'b1;
		pageRxWord <= w;
		pageRxIsNext <= nxt;
		@(posedge sys_clk);
		pageRxStrobe <= 1'b0;
		pageRxWord <= ~w;
		pageRxIsNext <= ~nxt;
	endtask : sendPage
	// One-cycle pulse: 0 done, 1 restart, 2 parallel fault
	task automatic pulse(input int sel);
		@(posedge sys_clk);
		if (sel == 0) autonegDone <= 1'b1;
		else if (sel == 1) autonegRestart <= 1'b1;
		else parallelFaultStrobe <= 1'b1;
		@(posedge sys_clk);
		autonegDone <= 1'b0;
		autonegRestart <= 1'b0;
		parallelFaultStrobe <= 1'b0;
	endtask : pulse
	task automatic setAble(input logic v);
		@(posedge sys_clk);
		partnerAutonegSeen <= v;
	endtask : setAble
endmodule : anps_link_partner_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the partner status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        sys_clk;
	logic        sys_rst;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pageRxStrobe;
	logic [15:0] pageRxWord;
	logic        pageRxIsNext;
	logic        autonegDone;
	logic        autonegRestart;
	logic        parallelFaultStrobe;
	logic        partnerAutonegSeen;
	logic [31:0] dummy;
	int          err_count;
	int          total_checks;
	localparam logic [7:0] PA = 8'h14;
	localparam logic [7:0] EA = 8'h18;
	anps_partner_status_regs i_anps_partner_status_regs (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pageRxStrobe(pageRxStrobe),
		.pageRxWord(pageRxWord), .pageRxIsNext(pageRxIsNext), .autonegDone(autonegDone),
		.autonegRestart(autonegRestart), .parallelFaultStrobe(parallelFaultStrobe),
		.partnerAutonegSeen(partnerAutonegSeen));
	anps_link_partner_model i_anps_link_partner_model (
		.sys_clk(sys_clk), .pageRxStrobe(pageRxStrobe), .pageRxWord(pageRxWord),
		.pageRxIsNext(pageRxIsNext), .autonegDone(autonegDone),
		.autonegRestart(autonegRestart), .parallelFaultStrobe(parallelFaultStrobe),
		.partnerAutonegSeen(partnerAutonegSeen));
	always #10 sys_clk = ~sys_clk;
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One bus cycle; request held until waitrequest is sampled low
	task automatic xfer(input logic [7:0] a, input logic rd, input logic [3:0] be,
		output logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= ~rd;
		avs_byteenable <= be;
		avs_writedata <= 32'hffff_bfff;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			$display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
			conclude();
		end
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
		logic [31:0] d;
		xfer(a, 1'b1, be, d);
		chk($sformatf("read %h", a), exp, d);
	endtask : rd
	function automatic logic [31:0] ex(input int fault, input int nextAble, input int pg,
		input int an);
		return {27'h0, fault[0], nextAble[0], 1'b1, pg[0], an[0]};
	endfunction : ex
	task automatic t_base();
		rd(PA, 4'hf, 32'h0);
		rd(EA, 4'hf, ex(0, 0, 0, 0));
		i_anps_link_partner_model.sendPage(16'h5aa1, 1'b0);
		rd(PA, 4'hf, 32'h4aa1);
		rd(EA, 4'hf, ex(0, 0, 1, 0));
		rd(EA, 4'hf, ex(0, 0, 0, 0));
		i_anps_link_partner_model.sendPage(16'ha55e, 1'b0);
		rd(PA, 4'hf, 32'ha55e);
	endtask : t_base
	task automatic t_write();
		xfer(PA, 1'b0, 4'hf, dummy);
		xfer(EA, 1'b0, 4'hf, dummy);
		rd(PA, 4'hf, 32'ha55e);
		rd(EA, 4'hf, ex(0, 1, 1, 0));
		rd(PA, 4'h2, 32'h0000_a500);
		rd(8'h1c, 4'hf, 32'h0);
		rd(8'h15, 4'hf, 32'h0);
	endtask : t_write
	task automatic t_next();
		i_anps_link_partner_model.sendPage(16'h1234, 1'b1);
		rd(PA, 4'hf, 32'ha55e);
		i_anps_link_partner_model.pulse(0);
		i_anps_link_partner_model.sendPage(16'h5123, 1'b1);
		rd(PA, 4'hf, 32'h5123);
		i_anps_link_partner_model.sendPage(16'haedc, 1'b1);
		rd(PA, 4'hf, 32'haedc);
		rd(EA, 4'hf, ex(0, 1, 1, 0));
	endtask : t_next
	task automatic t_fault();
		i_anps_link_partner_model.pulse(2);
		rd(EA, 4'hf, ex(1, 1, 0, 0));
		rd(EA, 4'hf, ex(1, 1, 0, 0));
		i_anps_link_partner_model.pulse(1);
		i_anps_link_partner_model.sendPage(16'h0021, 1'b0);
		rd(PA, 4'hf, 32'h0021);
		rd(EA, 4'hf, ex(0, 0, 1, 0));
		for (int v = 1; v >= 0; v--) begin
			i_anps_link_partner_model.setAble(v[0]);
			rd(EA, 4'hf, ex(0, 0, 0, v));
		end
	endtask : t_fault
	task automatic t_reset();
		i_anps_link_partner_model.sendPage(16'h8000, 1'b0);
		i_anps_link_partner_model.sendPage(16'h7fff, 1'b1);
		i_anps_link_partner_model.pulse(0);
		rd(PA, 4'hf, 32'h7fff);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(PA, 4'hf, 32'h0);
		i_anps_link_partner_model.sendPage(16'h8000, 1'b0);
		i_anps_link_partner_model.pulse(0);
		rd(PA, 4'hf, 32'h0);
		rd(EA, 4'hf, ex(0, 1, 1, 0));
	endtask : t_reset
	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		err_count = 0;
		total_checks = 0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_base();
		t_write();
		t_next();
		t_fault();
		t_reset();
		conclude();
	end
endmodule : tb
`default_nettype wire
